// [logic/byte_load_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "byte_load_defs.svh"

// How it works
// - Decode move grid and vector/refresh accumulator loads
// - Accept prefix plus second op code byte
// - Indexed loads: prefix, op code, displacement
// - Extended accumulator loads take 16-bit address
// - Address low byte first, then high
// - Register immediate load: op code, data
// - Indexed immediate: prefix, op, displacement, data
// - Displacement directly follows op code
// - Op codes fetched during op code cycle
// - Index plus signed displacement forms address
module byte_load_decode
   import byte_load_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Program memory byte stream
   output var  logic        byteReq,
   output var  logic        opcodeFetchCycle,
   input  wire logic        byteValid,
   input  wire logic [7:0]  byteData,
   // Index registers
   input  wire logic [15:0] indexRegX,
   input  wire logic [15:0] indexRegY,
   // Decoded load
   output var  logic        instrValid,
   output var  load_op_s    instr
);

   // ----------------------------------------
   // Main op code classification
   // ----------------------------------------
   function automatic load_op_s decodeMain(input logic [7:0] op, input logic indexed);
      load_op_s d;
      d = '0;
      d.dst = op[5:3];
      d.src = op[2:0];
      d.ptr = indexed ? PTR_INDEX : PTR_MAIN;
      if (op[7:6] == `GRP_MOVE && op != `OP_HALT)
      begin
         d.memRead  = (op[2:0] == `REG_MEM);
         d.memWrite = (op[5:3] == `REG_MEM);
         d.bad      = indexed && !(d.memRead || d.memWrite);
      end
      else if (op[7:6] == `GRP_LOW && op[2:0] == `SRC_IMM)
      begin
         d.hasImm   = 1'h1;
         d.memWrite = (op[5:3] == `REG_MEM);
         d.bad      = indexed && !d.memWrite;
      end
      else if (!indexed && (op == `OP_A_EXT || op == `OP_EXT_A))
      begin
         d.hasAddr  = 1'h1;
         d.memRead  = (op == `OP_A_EXT);
         d.memWrite = (op == `OP_EXT_A);
         d.dst      = d.memRead ? `REG_ACC : `REG_MEM;
         d.src      = d.memRead ? `REG_MEM : `REG_ACC;
      end
      else if (!indexed && (op == `OP_A_FIRST || op == `OP_A_SECOND ||
                            op == `OP_FIRST_A || op == `OP_SECOND_A))
      begin
         d.memRead  = op[`PAIR_DIR_BIT];
         d.memWrite = !op[`PAIR_DIR_BIT];
         d.ptr      = op[`PAIR_SEL_BIT] ? PTR_SECOND : PTR_FIRST;
         d.dst      = d.memRead ? `REG_ACC : `REG_MEM;
         d.src      = d.memRead ? `REG_MEM : `REG_ACC;
      end
      else
      begin
         d.bad = 1'h1;
      end
      return d;
   endfunction

   // ----------------------------------------
   // Sequencer state
   // ----------------------------------------
   fetch_state_e state;
   fetch_state_e next_state;
   logic         edPfx;
   logic         next_edPfx;
   logic         indexed;
   logic         next_indexed;
   logic         next_byteReq;
   logic         next_opcodeFetchCycle;
   logic         next_instrValid;
   load_op_s     next_instr;
   logic         take;
   logic [15:0]  idxBase;

   assign take    = byteReq && byteValid;
   assign idxBase = instr.idxY ? indexRegY : indexRegX;

   // Next state and decoded fields
   always_comb
   begin
      next_state   = state;
      next_edPfx   = edPfx;
      next_indexed = indexed;
      next_instr   = instr;
      case (state)
         ST_OP:
         begin
            if (take)
            begin
               next_edPfx   = 1'h0;
               next_indexed = 1'h0;
               next_instr   = '0;
               if (byteData == `PFX_EXT)
               begin
                  next_edPfx = 1'h1;
                  next_state = ST_OP2;
               end
               else if (byteData == `PFX_X || byteData == `PFX_Y)
               begin
                  next_indexed    = 1'h1;
                  next_instr.idxY = (byteData == `PFX_Y);
                  next_state      = ST_OP2;
               end
               else
               begin
                  next_instr = decodeMain(byteData, 1'h0);
                  if (next_instr.hasAddr)
                     next_state = ST_ADLO;
                  else if (next_instr.hasImm)
                     next_state = ST_IMM;
                  else
                     next_state = ST_ISSUE;
               end
            end
         end
         ST_OP2:
         begin
            if (take && edPfx)
            begin
               next_instr     = '0;
               next_instr.dst = `REG_ACC;
               next_instr.src = `REG_ACC;
               case (byteData)
                  `OP_A_VEC:  next_instr.special = SP_A_VEC;
                  `OP_A_RFSH: next_instr.special = SP_A_RFSH;
                  `OP_VEC_A:  next_instr.special = SP_VEC_A;
                  `OP_RFSH_A: next_instr.special = SP_RFSH_A;
                  default:    next_instr.bad     = 1'h1;
               endcase
               next_state = ST_ISSUE;
            end
            else if (take)
            begin
               next_instr      = decodeMain(byteData, 1'h1);
               next_instr.idxY = instr.idxY;
               next_state      = next_instr.bad ? ST_ISSUE : ST_DISP;
            end
         end
         ST_DISP:
         begin
            if (take)
            begin
               next_instr.addr = idxBase + {{8{byteData[`SIGN_BIT]}}, byteData};
               next_state      = instr.hasImm ? ST_IMM : ST_ISSUE;
            end
         end
         ST_IMM:
         begin
            if (take)
            begin
               next_instr.imm = byteData;
               next_state     = ST_ISSUE;
            end
         end
         ST_ADLO:
         begin
            if (take)
            begin
               next_instr.addr[7:0] = byteData;
               next_state           = ST_ADHI;
            end
         end
         ST_ADHI:
         begin
            if (take)
            begin
               next_instr.addr[15:8] = byteData;
               next_state            = ST_ISSUE;
            end
         end
         ST_ISSUE:
         begin
            next_state = ST_OP;
         end
         default:
         begin
            next_state = ST_OP;
         end
      endcase
      next_byteReq          = (next_state != ST_ISSUE);
      next_opcodeFetchCycle = (next_state == ST_OP || next_state == ST_OP2);
      next_instrValid       = (next_state == ST_ISSUE);
   end

   // State and output registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state            <= ST_OP;
         edPfx            <= 1'h0;
         indexed          <= 1'h0;
         byteReq          <= 1'h1;
         opcodeFetchCycle <= 1'h1;
         instrValid       <= 1'h0;
         instr            <= '0;
      end
      else
      begin
         state            <= next_state;
         edPfx            <= next_edPfx;
         indexed          <= next_indexed;
         byteReq          <= next_byteReq;
         opcodeFetchCycle <= next_opcodeFetchCycle;
         instrValid       <= next_instrValid;
         instr            <= next_instr;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   ed_special_a: assert property (
      (state == ST_OP2 && edPfx && take && byteData == `OP_A_VEC)
      |=> instrValid && !instr.bad && instr.special == SP_A_VEC)
      else $error("vector load not decoded");
   move_grid_a: assert property (
      (state == ST_OP && take && byteData[7:6] == `GRP_MOVE && byteData != `OP_HALT)
      |=> instrValid && !instr.bad && instr.dst == $past(byteData[5:3]) && instr.src == $past(byteData[2:0]))
      else $error("register move misdecoded");
   prefix_two_a: assert property (
      (state == ST_OP && take && (byteData == `PFX_EXT || byteData == `PFX_X || byteData == `PFX_Y))
      |=> state == ST_OP2 && opcodeFetchCycle && byteReq)
      else $error("prefix not followed by op code fetch");
   disp_after_op_a: assert property (
      (state == ST_DISP && $past(state) != ST_DISP) |-> $past(state) == ST_OP2 && indexed)
      else $error("displacement not right after op code");
   ext_three_a: assert property (
      (state == ST_OP && take && (byteData == `OP_A_EXT || byteData == `OP_EXT_A))
      |=> state == ST_ADLO && byteReq && !opcodeFetchCycle)
      else $error("extended load not three bytes");
   addr_high_next_a: assert property (
      (state == ST_ADLO && take) |=> state == ST_ADHI && byteReq && !opcodeFetchCycle)
      else $error("high address byte not fetched");
   addr_order_a: assert property (
      (state == ST_ADHI && take)
      |=> instrValid && instr.addr[15:8] == $past(byteData) && instr.addr[7:0] == $past(instr.addr[7:0]))
      else $error("address byte order wrong");
   imm_two_a: assert property (
      (state == ST_OP && take && byteData[7:6] == `GRP_LOW && byteData[2:0] == `SRC_IMM
       && byteData[5:3] != `REG_MEM) |=> state == ST_IMM)
      else $error("immediate byte not fetched");
   idx_imm_four_a: assert property (
      (state == ST_DISP && take && instr.hasImm) |=> state == ST_IMM)
      else $error("indexed immediate not four bytes");
   op_fetch_a: assert property (
      (state == ST_OP) |-> opcodeFetchCycle && byteReq && !instrValid)
      else $error("op code fetch not flagged");
   disp_sign_a: assert property (
      (state == ST_DISP && take)
      |=> instr.addr == 16'($past(idxBase) + {{8{$past(byteData[7])}}, $past(byteData)}))
      else $error("indexed address wrong");
   ptr_acc_a: assert property (
      (instrValid && (instr.ptr == PTR_FIRST || instr.ptr == PTR_SECOND))
      |-> (instr.memRead ? instr.dst : instr.src) == `REG_ACC && !instr.hasImm && !instr.hasAddr)
      else $error("pair pointer load misdecoded");

   idx_imm_c: cover property (state == ST_DISP && take && instr.hasImm ##[1:20] instrValid);
   ext_load_c: cover property (state == ST_ADHI && take ##1 instrValid);
   refresh_c: cover property (instrValid && instr.special == SP_A_RFSH);
   bad_op_c: cover property (instrValid && instr.bad);

endmodule // byte_load_decode
`default_nettype wire

// [logic/byte_load_defs.svh]
`ifndef BYTE_LOAD_DEFS_SVH
`define BYTE_LOAD_DEFS_SVH
// ----------------------------------------
// Prefix bytes
// ----------------------------------------
`define PFX_EXT      8'hED
`define PFX_X        8'hDD
`define PFX_Y        8'hFD
// ----------------------------------------
// Fixed op codes
// ----------------------------------------
`define OP_A_VEC     8'h57
`define OP_A_RFSH    8'h5F
`define OP_VEC_A     8'h47
`define OP_RFSH_A    8'h4F
`define OP_A_EXT     8'h3A
`define OP_EXT_A     8'h32
`define OP_A_FIRST   8'h0A
`define OP_A_SECOND  8'h1A
`define OP_FIRST_A   8'h02
`define OP_SECOND_A  8'h12
`define OP_HALT      8'h76
// ----------------------------------------
// Op code fields
// ----------------------------------------
`define GRP_MOVE     2'h1
`define GRP_LOW      2'h0
`define REG_MEM      3'h6
`define REG_ACC      3'h7
`define SRC_IMM      3'h6
`define SIGN_BIT     7
// Pair pointer op codes: bit 3 high reads memory, bit 4 picks the second pair
`define PAIR_DIR_BIT 3
`define PAIR_SEL_BIT 4
`endif

// [logic/byte_load_pkg.sv]
`default_nettype none
package byte_load_pkg;
   // Fetch sequencer states
   typedef enum logic [6:0]
   {
      ST_OP    = 7'h01,
      ST_OP2   = 7'h02,
      ST_DISP  = 7'h04,
      ST_IMM   = 7'h08,
      ST_ADLO  = 7'h10,
      ST_ADHI  = 7'h20,
      ST_ISSUE = 7'h40
   } fetch_state_e;

   // Memory pointer used by a memory operand
   typedef enum logic [1:0]
   {
      PTR_MAIN   = 2'h0,
      PTR_FIRST  = 2'h1,
      PTR_SECOND = 2'h2,
      PTR_INDEX  = 2'h3
   } ptr_sel_e;

   // Accumulator moves to and from vector and refresh registers
   typedef enum logic [2:0]
   {
      SP_NONE      = 3'h0,
      SP_A_VEC     = 3'h1,
      SP_A_RFSH    = 3'h2,
      SP_VEC_A     = 3'h3,
      SP_RFSH_A    = 3'h4
   } special_e;

   // One decoded load
   typedef struct packed
   {
      logic        bad;
      logic        memRead;
      logic        memWrite;
      logic        hasImm;
      logic        hasAddr;
      ptr_sel_e    ptr;
      logic        idxY;
      special_e    special;
      logic [2:0]  dst;
      logic [2:0]  src;
      logic [7:0]  imm;
      logic [15:0] addr;
   } load_op_s;
endpackage
`default_nettype wire

// [dv/prog_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Program memory byte source
// ----
module prog_mem_model
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Byte stream
   input  wire logic       byteReq,
   output var  logic       byteValid,
   output var  logic [7:0] byteData
);
   logic [7:0] mem [0:255];
   int         len = 0;
   int         ptr = 0;
   logic       slow = 1'h0;
   logic       gap = 1'h0;

   // Append one program byte
   task automatic put(input logic [7:0] b);
      mem[len[7:0]] = b;
      len++;
   endtask

   // Step past each taken byte; reset drops unread bytes; slow mode idles one cycle after a take
   always @(posedge clk)
   begin
      gap <= 1'h0;
      if (!resetn)
         ptr <= len;
      else if (byteReq && byteValid)
      begin
         ptr <= ptr + 1;
         gap <= slow;
      end
   end

   // Offer held byte; idle line toggles so stale data never looks valid
   always @(negedge clk)
   begin
      byteValid <= (ptr < len) && !gap;
      byteData  <= ((ptr < len) && !gap) ? mem[ptr[7:0]] : ~byteData;
   end
endmodule // prog_mem_model
`default_nettype wire

// [dv/tb_byte_load_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHECK(name, exp, got) \
   begin \
      totalChecks++; \
      if ((got) !== (exp)) \
      begin \
         errTotal++; \
         $display("unexpected %s: expected %h, seen %h", name, exp, got); \
      end \
   end
module tb_byte_load_decode
   import byte_load_pkg::*;
;
   // Row: bytes, count, {bad,read,write,imm,addr}, special, pointer, dst, src, value
   typedef struct packed
   {
      logic [31:0] b;
      logic [2:0]  n;
      logic [4:0]  f;
      logic [2:0]  sp;
      logic [1:0]  p;
      logic [2:0]  d;
      logic [2:0]  s;
      logic [15:0] v;
   } row_s;
   logic        clk;
   logic        resetn;
   logic        byteReq;
   logic        opcodeFetchCycle;
   logic        byteValid;
   logic [7:0]  byteData;
   logic [15:0] indexRegX;
   logic [15:0] indexRegY;
   logic        instrValid;
   load_op_s    instr;
   int          errTotal = 0;
   int          totalChecks = 0;
   int          takes = 0;
   logic [3:0]  fetchMask = 4'h0;
   row_s        rows [0:22] = '{
      {32'h48000000, 3'h1, 5'h00, 3'h0, 2'h0, 3'h1, 3'h0, 16'h0},
      {32'h7E000000, 3'h1, 5'h08, 3'h0, 2'h0, 3'h7, 3'h6, 16'h0},
      {32'h70000000, 3'h1, 5'h04, 3'h0, 2'h0, 3'h6, 3'h0, 16'h0},
      {32'h0A000000, 3'h1, 5'h08, 3'h0, 2'h1, 3'h7, 3'h6, 16'h0},
      {32'h1A000000, 3'h1, 5'h08, 3'h0, 2'h2, 3'h7, 3'h6, 16'h0},
      {32'h02000000, 3'h1, 5'h04, 3'h0, 2'h1, 3'h6, 3'h7, 16'h0},
      {32'h12000000, 3'h1, 5'h04, 3'h0, 2'h2, 3'h6, 3'h7, 16'h0},
      {32'h3A341200, 3'h3, 5'h09, 3'h0, 2'h0, 3'h7, 3'h6, 16'h1234},
      {32'h32CDAB00, 3'h3, 5'h05, 3'h0, 2'h0, 3'h6, 3'h7, 16'hABCD},
      {32'h3E5A0000, 3'h2, 5'h02, 3'h0, 2'h0, 3'h7, 3'h6, 16'h005A},
      {32'h06A50000, 3'h2, 5'h02, 3'h0, 2'h0, 3'h0, 3'h6, 16'h00A5},
      {32'h36810000, 3'h2, 5'h06, 3'h0, 2'h0, 3'h6, 3'h6, 16'h0081},
      {32'hDD468000, 3'h3, 5'h08, 3'h0, 2'h3, 3'h0, 3'h6, 16'h0},
      {32'hFD7E0500, 3'h3, 5'h08, 3'h0, 2'h3, 3'h7, 3'h6, 16'h0},
      {32'hFD777F00, 3'h3, 5'h04, 3'h0, 2'h3, 3'h6, 3'h7, 16'h0},
      {32'hDD36FEC3, 3'h4, 5'h06, 3'h0, 2'h3, 3'h6, 3'h6, 16'h00C3},
      {32'hED570000, 3'h2, 5'h00, 3'h1, 2'h0, 3'h0, 3'h0, 16'h0},
      {32'hED5F0000, 3'h2, 5'h00, 3'h2, 2'h0, 3'h0, 3'h0, 16'h0},
      {32'hED470000, 3'h2, 5'h00, 3'h3, 2'h0, 3'h0, 3'h0, 16'h0},
      {32'hED4F0000, 3'h2, 5'h00, 3'h4, 2'h0, 3'h0, 3'h0, 16'h0},
      {32'h76000000, 3'h1, 5'h10, 3'h0, 2'h0, 3'h0, 3'h0, 16'h0},
      {32'hED000000, 3'h2, 5'h10, 3'h0, 2'h0, 3'h0, 3'h0, 16'h0},
      {32'hDD400000, 3'h2, 5'h10, 3'h0, 2'h0, 3'h0, 3'h0, 16'h0}};

   // ----
   // Clock, design and memory
   // ----
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   byte_load_decode u_dut (.clk(clk), .resetn(resetn), .byteReq(byteReq), .opcodeFetchCycle(opcodeFetchCycle),
      .byteValid(byteValid), .byteData(byteData), .indexRegX(indexRegX), .indexRegY(indexRegY),
      .instrValid(instrValid), .instr(instr));
   prog_mem_model u_mem (.clk(clk), .resetn(resetn), .byteReq(byteReq), .byteValid(byteValid),
      .byteData(byteData));

   // Record fetch flag of every taken byte; cleared by reset and by each decode
   always @(posedge clk)
      if (!resetn || instrValid)
      begin
         takes <= 0;
         fetchMask <= 4'h0;
      end
      else if (byteReq && byteValid)
      begin
         fetchMask[takes[1:0]] <= opcodeFetchCycle;
         takes <= takes + 1;
      end

   // ----
   // Tasks
   // ----
   task automatic summarize();
      if (errTotal == 0 && totalChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Feed one instruction, wait for its decode, compare
   task automatic run(input row_s r);
      logic [15:0] ea;
      logic [7:0]  pfx;
      logic        seen;
      pfx = r.b[31:24];
      seen = 1'h0;
      for (int i = 0; i < r.n; i++)
         u_mem.put(r.b[31 - 8 * i -: 8]);
      for (int k = 0; k < 40 && !seen; k++)
      begin
         @(negedge clk);
         seen = (instrValid === 1'b1);
      end
      ea = ((pfx == 8'hFD) ? indexRegY : indexRegX) + {{8{r.b[15]}}, r.b[15:8]};
      `CHECK("decoded", 1'h1, seen)
      `CHECK("issueReq", 1'h0, byteReq)
      `CHECK("length", r.n, takes[2:0])
      `CHECK("opfetch", (pfx == 8'hED || pfx == 8'hDD || pfx == 8'hFD) ? 4'h3 : 4'h1, fetchMask)
      if (r.f[4])
         `CHECK("bad", 1'b1, instr.bad)
      else
      begin
         `CHECK("kind", r.f, {instr.bad, instr.memRead, instr.memWrite, instr.hasImm, instr.hasAddr})
         `CHECK("special", r.sp, instr.special)
      end
      if (!r.f[4] && r.sp == 3'h0)
         `CHECK("regs", {r.d, r.s}, {instr.dst, instr.src})
      if ((r.f[3] || r.f[2]) && !r.f[0])
         `CHECK("pointer", r.p, instr.ptr)
      if (r.p == 2'h3)
      begin
         `CHECK("indexed", ea, instr.addr)
         `CHECK("idxY", pfx == 8'hFD, instr.idxY)
      end
      if (r.f[0])
         `CHECK("address", r.v, instr.addr)
      if (r.f[1])
         `CHECK("imm", r.v[7:0], instr.imm)
   endtask

   // ----
   // Main sequence
   // ----
   initial
   begin
      resetn = 1'b0;
      indexRegX = 16'h1234;
      indexRegY = 16'hFFF0;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      for (int pass = 0; pass < 2; pass++)
      begin
         u_mem.slow = pass[0];
         indexRegX = indexRegX + 16'h7F00;
         foreach (rows[i])
            run(rows[i]);
      end
      // Reset in mid-instruction, then a clean decode
      u_mem.put(8'h3A);
      u_mem.put(8'h34);
      repeat (2) @(negedge clk);
      resetn = 1'b0;
      #1;
      `CHECK("rstReq", 1'h1, byteReq)
      `CHECK("rstFetch", 1'h1, opcodeFetchCycle)
      `CHECK("rstValid", 1'h0, instrValid)
      `CHECK("rstInstr", load_op_s'(0), instr)
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      run(rows[7]);
      summarize();
   end

   // Watchdog
   initial
   begin
      #100000;
      errTotal++;
      summarize();
   end
endmodule // tb_byte_load_decode
`default_nettype wire
